// ### include/cmpdc_map.svh
// register map, field positions, reset values and selector codes
// Summary of operation
// RQ1: with sync set, latch output on each falling edge of timer clock
// RQ2: sync latch uses the prescaled timer clock when a prescaler is used
// RQ3: timer counts on rising edges; synced output changes on falling edges
// RQ4: separate rise and fall detectors set the flag when their enable is set
// RQ5: software clears the flag; a coinciding edge keeps it set
// RQ6: edge detectors stay active while the comparator is off
// RQ7: request reaches cpu only with flag, enable, peripheral and global gates
// RQ8: plus select: pins 0,1, unconnected, dac, reference, ground
// RQ9: minus select: pins 0 to 3, unconnected, reference, ground
// RQ10: comparator off disconnects all inputs regardless of selects
// RQ11: polarity bit 4 inverts output; result bit reflects polarity
// RQ12: control bit 7 enables comparator; clear means disabled, no power
// RQ13: control bit 0 selects synchronous or asynchronous output path
// RQ14: control bit 1 is the hysteresis enable, read/write, reset 0
// RQ15: edge enable bit 1 rising, bit 0 falling; other bits read 0
// RQ16: mirror register shows first result bit 0, second result bit 1
// RQ17: synced outputs stop in sleep when timer runs on system clock
// RQ18: enabled comparator interrupt wakes the device from sleep
// RQ19: active output with shutdown enable suspends the waveform generator
// RQ20: output is selectable as gate source of the gate timer
// RQ21: software should enable sync when the comparator gates the timer
// RQ22: port reads return 0 for pins configured as analog inputs
// RQ23: internal output sampled once per instruction cycle
// RQ24: edges compare current output with previous instruction cycle value
`ifndef CMPDC_MAP_SVH
`define CMPDC_MAP_SVH
`define CMPDC_ADDR_CTRL 12'h000
`define CMPDC_ADDR_EDGE 12'h004
`define CMPDC_ADDR_NSEL 12'h008
`define CMPDC_ADDR_PSEL 12'h00c
`define CMPDC_ADDR_MIRR 12'h010
`define CMPDC_ADDR_IRQ 12'h014
`define CMPDC_ADDR_PORT 12'h018
`define CMPDC_ADDR_ANSEL 12'h01c
`define CMPDC_BIT_ON 7
`define CMPDC_BIT_OUT 6
`define CMPDC_BIT_POL 4
`define CMPDC_BIT_HYS 1
`define CMPDC_BIT_SYNC 0
`define CMPDC_BIT_RISE 1
`define CMPDC_BIT_FALL 0
`define CMPDC_BIT_FLAG 0
`define CMPDC_BIT_IE 1
`define CMPDC_BIT_PGATE 2
`define CMPDC_BIT_GGATE 3
`define CMPDC_RST_REG 8'h00
`define CMPDC_INSTR_DIV 4
`define CMPDC_P_PIN0 3'h0
`define CMPDC_P_PIN1 3'h1
`define CMPDC_P_DAC 3'h5
`define CMPDC_P_FREF 3'h6
`define CMPDC_P_GND 3'h7
`define CMPDC_N_FREF 3'h6
`define CMPDC_N_GND 3'h7
`endif

// ### include/cmpdc_pkg.sv
// types of the comparator digital control block
package cmpdc_pkg;
  // one-hot analog switch controls toward the input multiplexers
  typedef struct packed {
    logic [1:0] pin;
    logic dac;
    logic fref;
    logic gnd;
  } cmpdc_plus_sw_t;
  typedef struct packed {
    logic [3:0] pin;
    logic fref;
    logic gnd;
  } cmpdc_minus_sw_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] edge_en;
    logic [2:0] nsel;
    logic [2:0] psel;
    logic [3:0] irqc;
    logic [7:0] ansel;
    logic [1:0] div;
    logic raw_s1;
    logic raw_s2;
    logic tclk_s1;
    logic tclk_s2;
    logic tclk_d;
    logic res_q;
    logic res_prev;
    logic sync_q;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    logic other_s1;
    logic other_s2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wake;
    logic shut;
    logic gate;
    logic out_pin;
    cmpdc_plus_sw_t psw;
    cmpdc_minus_sw_t nsw;
  } cmpdc_state_t;
endpackage : cmpdc_pkg

// ### src/cmpdc_top.sv
// comparator channel digital control with apb register slave
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "cmpdc_map.svh"
module cmpdc_top
  import cmpdc_pkg::*;
(
  input wire logic pclk, // 250 mhz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on write to unmapped address
  input wire logic cmp_raw, // analog comparator decision, async
  input wire logic other_result, // second channel result for the mirror
  input wire logic timer_clk, // prescaled gate timer clock, async level
  input wire logic timer_on_sysclk, // timer clocked by system clock
  input wire logic sleep_mode, // device is in sleep
  input wire logic shutdown_source_enable, // generator enable for source
  input wire logic [7:0] port_pins, // port pin levels, async
  output logic comparator_on_o, // analog enable
  output logic hysteresis_on_o, // analog hysteresis enable
  output cmpdc_plus_sw_t plus_sw, // plus input switches
  output cmpdc_minus_sw_t minus_sw, // minus input switches
  output logic gate_source, // comparator gate source to timer
  output logic out_pin, // comparator output toward pin
  output logic shutdown_req, // waveform generator suspend
  output logic irq_req, // interrupt request to cpu
  output logic wake_req // wake from sleep
);
  cmpdc_state_t r_ff, nxt_r;
  logic instr_en, result, post_pol, rise, fall, wr, rd, tfall, out_path;
  logic clr_flag;

  // ==========================================================
  // decoders
  function automatic cmpdc_plus_sw_t plus_dec(input logic on,
                                              input logic [2:0] s);
    cmpdc_plus_sw_t v;
    v = '0;
    if (on) begin // see RQ10
      case (s) // see RQ8
        `CMPDC_P_PIN0: v.pin = 2'h1;
        `CMPDC_P_PIN1: v.pin = 2'h2;
        `CMPDC_P_DAC: v.dac = 1'h1;
        `CMPDC_P_FREF: v.fref = 1'h1;
        `CMPDC_P_GND: v.gnd = 1'h1;
        default: v = '0;
      endcase
    end
    return v;
  endfunction : plus_dec

  function automatic cmpdc_minus_sw_t minus_dec(input logic on,
                                                input logic [2:0] s);
    cmpdc_minus_sw_t v;
    v = '0;
    if (on) begin // see RQ10
      case (s) // see RQ9
        `CMPDC_N_FREF: v.fref = 1'h1;
        `CMPDC_N_GND: v.gnd = 1'h1;
        default: begin
          if (!s[2]) begin
            v.pin = 4'h1 << s[1:0];
          end
        end
      endcase
    end
    return v;
  endfunction : minus_dec

  // ==========================================================
  // combinational next state
  always_comb begin
    nxt_r = r_ff;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    instr_en = (r_ff.div == 2'(`CMPDC_INSTR_DIV - 1));
    nxt_r.div = r_ff.div + 2'h1;
    nxt_r.raw_s1 = cmp_raw;
    nxt_r.raw_s2 = r_ff.raw_s1;
    nxt_r.tclk_s1 = timer_clk;
    nxt_r.tclk_s2 = r_ff.tclk_s1;
    nxt_r.tclk_d = r_ff.tclk_s2;
    nxt_r.port_s1 = port_pins;
    nxt_r.port_s2 = r_ff.port_s1;
    nxt_r.other_s1 = other_result;
    nxt_r.other_s2 = r_ff.other_s1;
    // off comparator reads low before polarity so toggling on or
    // polarity still makes an edge; see RQ6
    result = r_ff.raw_s2 && r_ff.ctrl[`CMPDC_BIT_ON]; // see RQ12
    post_pol = result ^ r_ff.ctrl[`CMPDC_BIT_POL]; // see RQ11
    if (instr_en) begin
      nxt_r.res_q = post_pol; // see RQ23
      nxt_r.res_prev = r_ff.res_q; // see RQ24
    end
    rise = instr_en && r_ff.res_q && !r_ff.res_prev; // see RQ24
    fall = instr_en && !r_ff.res_q && r_ff.res_prev;
    // falling edge of prescaled timer clock; rising edges count
    tfall = r_ff.tclk_d && !r_ff.tclk_s2; // see RQ2 RQ3
    // timer halts in sleep when it runs from system clock
    if (tfall && !(sleep_mode && timer_on_sysclk)) begin // see RQ17
      nxt_r.sync_q = r_ff.res_q; // see RQ1
    end
    out_path = r_ff.ctrl[`CMPDC_BIT_SYNC] ? r_ff.sync_q : r_ff.res_q;
    // see RQ13
    nxt_r.gate = out_path; // see RQ20
    nxt_r.out_pin = out_path;
    nxt_r.shut = r_ff.res_q && shutdown_source_enable; // see RQ19
    clr_flag = 1'h0;
    nxt_r.pready = 1'h1;
    nxt_r.pslverr = 1'h0;
    if (wr) begin
      case (paddr)
        `CMPDC_ADDR_CTRL: begin
          nxt_r.ctrl = pwdata[7:0] & 8'h93; // see RQ14
        end
        `CMPDC_ADDR_EDGE: nxt_r.edge_en = pwdata[1:0]; // see RQ15
        `CMPDC_ADDR_NSEL: nxt_r.nsel = pwdata[2:0];
        `CMPDC_ADDR_PSEL: nxt_r.psel = pwdata[2:0];
        `CMPDC_ADDR_IRQ: begin
          // software can only clear the flag, never set it; see RQ5
          nxt_r.irqc[3:1] = pwdata[3:1];
          clr_flag = !pwdata[`CMPDC_BIT_FLAG];
        end
        `CMPDC_ADDR_ANSEL: nxt_r.ansel = pwdata[7:0];
        `CMPDC_ADDR_MIRR, `CMPDC_ADDR_PORT: nxt_r.pslverr = 1'h0;
        default: nxt_r.pslverr = 1'h1;
      endcase
    end
    // set beats clear on a coinciding edge; see RQ5
    if (clr_flag) begin
      nxt_r.irqc[`CMPDC_BIT_FLAG] = 1'h0;
    end
    if ((rise && r_ff.edge_en[`CMPDC_BIT_RISE])
        || (fall && r_ff.edge_en[`CMPDC_BIT_FALL])) begin // see RQ4
      nxt_r.irqc[`CMPDC_BIT_FLAG] = 1'h1;
    end
    if (rd) begin
      nxt_r.prdata = '0;
      case (paddr)
        `CMPDC_ADDR_CTRL: begin
          nxt_r.prdata[7:0] = r_ff.ctrl;
          nxt_r.prdata[`CMPDC_BIT_OUT] = r_ff.res_q; // see RQ11
        end
        `CMPDC_ADDR_EDGE: nxt_r.prdata[1:0] = r_ff.edge_en; // see RQ15
        `CMPDC_ADDR_NSEL: nxt_r.prdata[2:0] = r_ff.nsel;
        `CMPDC_ADDR_PSEL: nxt_r.prdata[2:0] = r_ff.psel;
        `CMPDC_ADDR_MIRR: begin
          nxt_r.prdata[1:0] = {r_ff.other_s2, r_ff.res_q}; // see RQ16
        end
        `CMPDC_ADDR_IRQ: nxt_r.prdata[3:0] = r_ff.irqc;
        `CMPDC_ADDR_PORT: begin
          nxt_r.prdata[7:0] = r_ff.port_s2 & ~r_ff.ansel; // see RQ22
        end
        `CMPDC_ADDR_ANSEL: nxt_r.prdata[7:0] = r_ff.ansel;
        default: nxt_r.prdata = '0;
      endcase
    end
    nxt_r.irq = r_ff.irqc[`CMPDC_BIT_FLAG] && r_ff.irqc[`CMPDC_BIT_IE]
      && r_ff.irqc[`CMPDC_BIT_PGATE] && r_ff.irqc[`CMPDC_BIT_GGATE];
    // see RQ7
    // wake needs only the channel enable, not the global gates
    nxt_r.wake = r_ff.irqc[`CMPDC_BIT_FLAG]
      && r_ff.irqc[`CMPDC_BIT_IE]; // see RQ18
    nxt_r.psw = plus_dec(r_ff.ctrl[`CMPDC_BIT_ON], r_ff.psel);
    nxt_r.nsw = minus_dec(r_ff.ctrl[`CMPDC_BIT_ON], r_ff.nsel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
      r_ff.pready <= 1'h1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign comparator_on_o = r_ff.ctrl[`CMPDC_BIT_ON];
  assign hysteresis_on_o = r_ff.ctrl[`CMPDC_BIT_HYS];
  assign plus_sw = r_ff.psw;
  assign minus_sw = r_ff.nsw;
  assign gate_source = r_ff.gate;
  assign out_pin = r_ff.out_pin;
  assign shutdown_req = r_ff.shut;
  assign irq_req = r_ff.irq;
  assign wake_req = r_ff.wake;

  // ==========================================================
  // assertions
  a_flag_rise_set: assert property (@(posedge pclk) disable iff (!presetn)
    rise && r_ff.edge_en[`CMPDC_BIT_RISE] |=> r_ff.irqc[0]) // see RQ4
    else $error("rise edge did not set flag");
  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clr_flag && fall && r_ff.edge_en[`CMPDC_BIT_FALL] |=> r_ff.irqc[0])
    // see RQ5
    else $error("clear beat a coinciding edge");
  a_irq_gates: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> $past(r_ff.irqc) == 4'hf) // see RQ7
    else $error("irq without all gates");
  a_inputs_off: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(r_ff.ctrl[7]) |-> plus_sw == '0 && minus_sw == '0) // see RQ10
    else $error("inputs connected while off");
  a_plus_dac: assert property (@(posedge pclk) disable iff (!presetn)
    r_ff.ctrl[7] && r_ff.psel == 3'h5 |=> plus_sw.dac) // see RQ8
    else $error("dac not selected");
  a_minus_pin3: assert property (@(posedge pclk) disable iff (!presetn)
    r_ff.ctrl[7] && r_ff.nsel == 3'h3 |=> minus_sw.pin == 4'h8) // see RQ9
    else $error("minus pin 3 not selected");
  a_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tfall |=> $stable(r_ff.sync_q)) // see RQ1
    else $error("sync latch moved off a falling edge");
  a_shut_follow: assert property (@(posedge pclk) disable iff (!presetn)
    r_ff.res_q && shutdown_source_enable |=> shutdown_req) // see RQ19
    else $error("shutdown not raised");
  a_edge_mask: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == `CMPDC_ADDR_EDGE |=> prdata[31:2] == '0) // see RQ15
    else $error("edge register upper bits nonzero");
endmodule : cmpdc_top

// ### testbench/cmpdc_tb.sv
// self-checking bench for the comparator digital control block
`timescale 1ns/10ps
`include "cmpdc_map.svh"
module tb
  import cmpdc_pkg::*;
;
// ==========
// signals
logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, q;
logic cmp_raw, other_result, timer_clk, timer_on_sysclk, sleep_mode;
logic shutdown_source_enable, comparator_on_o, hysteresis_on_o;
logic gate_source, out_pin, shutdown_req, irq_req, wake_req;
logic [7:0] port_pins;
cmpdc_plus_sw_t plus_sw;
cmpdc_minus_sw_t minus_sw;
int n_fail = 0;
int num_checks = 0;
int cyc = 0;
typedef struct packed {
  logic [11:0] a;
  logic [31:0] d;
  logic [31:0] e;
} cmpdc_tbrow_t;
// writes carry junk in reserved bits; readback must drop them
cmpdc_tbrow_t rows [10] = '{
  '{`CMPDC_ADDR_CTRL, 32'hffff_ff2f, 32'h03},
  '{`CMPDC_ADDR_CTRL, 32'h0000_00c2, 32'h82},
  '{`CMPDC_ADDR_EDGE, 32'hffff_ffff, 32'h03},
  '{`CMPDC_ADDR_NSEL, 32'hffff_fffb, 32'h03},
  '{`CMPDC_ADDR_PSEL, 32'h0000_00fd, 32'h05},
  '{`CMPDC_ADDR_ANSEL, 32'h0000_01a5, 32'ha5},
  '{`CMPDC_ADDR_MIRR, 32'h0000_00ff, 32'h00},
  '{`CMPDC_ADDR_PORT, 32'h0000_00ff, 32'h00},
  '{`CMPDC_ADDR_IRQ, 32'h0000_000f, 32'h0e},
  '{12'h020, 32'hffff_ffff, 32'h00}};
cmpdc_top i_cmpdc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .cmp_raw, .other_result,
  .timer_clk, .timer_on_sysclk, .sleep_mode, .shutdown_source_enable,
  .port_pins, .comparator_on_o, .hysteresis_on_o, .plus_sw, .minus_sw,
  .gate_source, .out_pin, .shutdown_req, .irq_req, .wake_req);
// ==========
// tasks
task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
  num_checks++;
  if (got !== exp) begin
    n_fail++;
    $display("wrong value at %0t got %h exp %h", $time, got, exp);
  end
endtask : chk_word
task automatic chk_bit(input logic got, input logic exp);
  num_checks++;
  if (got !== exp) begin
    n_fail++;
    $display("wrong value at %0t got %h exp %h", $time, got, exp);
  end
endtask : chk_bit
task automatic tally_and_finish();
  $display("checks %0d mismatches %0d", num_checks, n_fail);
  if (n_fail == 0 && num_checks > 0) begin
    $display("Regression OK");
  end else begin
    $display("Regression broken");
  end
  $finish;
endtask : tally_and_finish
task automatic idle(input int n);
  repeat (n) @(posedge pclk);
endtask : idle
// an idle edge after each transfer keeps psel from being set twice at once
task automatic apb(input logic wr, input logic [11:0] a,
                   input logic [31:0] d);
  int n;
  n = 0;
  psel <= 1'b1;
  pwrite <= wr;
  paddr <= a;
  pwdata <= d;
  @(posedge pclk);
  penable <= 1'b1;
  @(posedge pclk);
  while (pready !== 1'b1 && n < 20) begin
    n++;
    @(posedge pclk);
  end
  if (n == 20) begin
    n_fail++;
    tally_and_finish();
  end
  q = prdata;
  psel <= 1'b0;
  penable <= 1'b0;
  @(posedge pclk);
endtask : apb
task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
  apb(1'b0, a, 32'h0);
  chk_word(q, e);
endtask : rd_chk
// one falling edge of the timer clock; latency of the sync path fits in 12
task automatic tpulse();
  timer_clk <= 1'b1;
  idle(8);
  timer_clk <= 1'b0;
  idle(12);
endtask : tpulse
function automatic logic [4:0] pexp(input logic [2:0] c);
  pexp = c < 2 ? 5'h08 << c : c == 5 ? 5'h04 : c == 6 ? 5'h02 :
         c == 7 ? 5'h01 : 5'h00;
endfunction : pexp
function automatic logic [5:0] nexp(input logic [2:0] c);
  nexp = c < 4 ? 6'h04 << c : c == 6 ? 6'h02 : c == 7 ? 6'h01 : 6'h00;
endfunction : nexp
// ==========
// clock, timeout and tests
initial begin
  pclk = 1'b0;
  forever #2 pclk = ~pclk;
end
always @(posedge pclk) begin
  cyc <= cyc + 1;
  if (cyc == 20000) begin
    n_fail++;
    tally_and_finish();
  end
end
initial begin
  {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
  {cmp_raw, other_result, timer_clk, timer_on_sysclk, sleep_mode} = '0;
  shutdown_source_enable = 1'b1;
  port_pins = 8'h00;
  idle(6);
  presetn <= 1'b1;
  idle(1);
  chk_bit(pready, 1'b1);
  foreach (rows[i]) rd_chk(rows[i].a, 32'h0); // reset value
  foreach (rows[i]) begin
    apb(1'b1, rows[i].a, rows[i].d);
    rd_chk(rows[i].a, rows[i].e);
  end
  chk_bit(comparator_on_o, 1'b1);
  chk_bit(hysteresis_on_o, 1'b1);
  $display("test registers done");
  for (int c = 0; c < 8; c++) begin
    apb(1'b1, `CMPDC_ADDR_PSEL, c);
    apb(1'b1, `CMPDC_ADDR_NSEL, c);
    idle(2);
    chk_word({27'h0, plus_sw}, {27'h0, pexp(c)});
    chk_word({26'h0, minus_sw}, {26'h0, nexp(c)});
  end
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h00);
  idle(2);
  chk_word({21'h0, plus_sw, minus_sw}, 32'h0);
  $display("test selects done");
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h80);
  apb(1'b1, `CMPDC_ADDR_EDGE, 32'h02);
  cmp_raw <= 1'b1;
  other_result <= 1'b1;
  idle(24);
  rd_chk(`CMPDC_ADDR_CTRL, 32'hc0);
  rd_chk(`CMPDC_ADDR_IRQ, 32'h0f);
  rd_chk(`CMPDC_ADDR_MIRR, 32'h03);
  chk_bit(irq_req, 1'b1);
  chk_bit(shutdown_req, 1'b1);
  apb(1'b1, `CMPDC_ADDR_IRQ, 32'h0e);
  idle(2);
  chk_bit(irq_req, 1'b0);
  cmp_raw <= 1'b0;
  idle(24);
  rd_chk(`CMPDC_ADDR_IRQ, 32'h0e); // fall masked
  chk_bit(shutdown_req, 1'b0);
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h10);
  idle(24);
  rd_chk(`CMPDC_ADDR_CTRL, 32'h50);
  rd_chk(`CMPDC_ADDR_IRQ, 32'h0f); // edge while off
  apb(1'b1, `CMPDC_ADDR_IRQ, 32'h07);
  sleep_mode <= 1'b1;
  idle(4);
  chk_bit(irq_req, 1'b0);
  chk_bit(wake_req, 1'b1);
  apb(1'b1, `CMPDC_ADDR_IRQ, 32'h05);
  idle(4);
  chk_bit(wake_req, 1'b0);
  sleep_mode <= 1'b0;
  apb(1'b1, `CMPDC_ADDR_EDGE, 32'h01);
  apb(1'b1, `CMPDC_ADDR_IRQ, 32'h0e);
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h00);
  idle(24);
  rd_chk(`CMPDC_ADDR_IRQ, 32'h0f);
  chk_bit(irq_req, 1'b1);
  $display("test edges done");
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h81); // sync on while gating
  tpulse();
  chk_bit(out_pin, 1'b0);
  timer_clk <= 1'b1;
  cmp_raw <= 1'b1;
  idle(24);
  chk_bit(out_pin, 1'b0); // held until falling edge
  timer_clk <= 1'b0;
  idle(12);
  chk_bit(out_pin, 1'b1);
  chk_bit(gate_source, 1'b1);
  cmp_raw <= 1'b0;
  tpulse();
  timer_on_sysclk <= 1'b1;
  sleep_mode <= 1'b1;
  cmp_raw <= 1'b1;
  tpulse();
  chk_bit(out_pin, 1'b0);
  sleep_mode <= 1'b0;
  timer_on_sysclk <= 1'b0;
  tpulse();
  chk_bit(out_pin, 1'b1);
  apb(1'b1, `CMPDC_ADDR_CTRL, 32'h80);
  cmp_raw <= 1'b0;
  idle(16);
  chk_bit(out_pin, 1'b0); // no timer edge needed
  $display("test sync done");
  port_pins <= 8'hff;
  idle(6);
  rd_chk(`CMPDC_ADDR_PORT, 32'h5a);
  presetn <= 1'b0;
  idle(2);
  presetn <= 1'b1;
  idle(1);
  rd_chk(`CMPDC_ADDR_ANSEL, 32'h00);
  rd_chk(`CMPDC_ADDR_EDGE, 32'h00);
  $display("test port and reset done");
  tally_and_finish();
end
endmodule : tb
